/* File: tcr_pkg.sv */
// Constants, types and helpers shared by the timer control block
// How it works
// - First control register: channel A selector bits 7:6, B 5:4, C 3:2.
// - Selector 1x connects compare output, 01 only in non-PWM (A also in four PWM modes); direction bit gates driver.
// - Waveform mode is first reg bits 1:0 plus second reg bits 4:3.
// - Non-PWM: 00 off, 01 toggle, 10 clear, 11 set on match.
// - Fast PWM: 10 clears on match, sets at bottom; 11 the inverse.
// - Fast PWM: match at top ignored when selector high bit set.
// - Dual slope: 10 clears on up match, sets on down; 11 reverse.
// - Second reg bit 7 enables four-equal-sample capture filter.
// - Second reg bit 6 picks capture edge: 0 falling, 1 rising.
// - Capture edge copies counter to capture register and sets flag.
// - Modes using capture register as top disable capture.
// - Clock selector 000 stops the counter: no count ticks.
// - Clock selector offers prescaled divisions including 64, 256, 1024.
// - Selector 110 counts falling, 111 rising edges of count pin.
// - External count pin counts even when configured as output.
// - First control register fully read/write, resets to zero.
// - Dual slope: code 10 non-inverted sense, code 11 inverted sense.
`default_nettype none
package tcr_pkg;
  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [3:0] ADDR_CTRL_FIRST  = 4'h0;
  localparam logic [3:0] ADDR_CTRL_SECOND = 4'h4;
  localparam logic [3:0] ADDR_STATUS      = 4'h8;
  localparam logic [3:0] ADDR_CAPTURE     = 4'hC;
  localparam logic [7:0] CTRL_RESET       = 8'h00;
  localparam logic [7:0] SECOND_WR_MASK   = 8'hDF;
  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int SEL_A_HI = 7;
  localparam int SEL_B_HI = 5;
  localparam int SEL_C_HI = 3;
  localparam int FILTER_BIT = 7;
  localparam int EDGE_BIT   = 6;
  localparam int FLAG_BIT   = 0;
  localparam int NCHAN      = 3;
  localparam int FILTER_LEN = 4;
  // ****************************************************************
  // Modes and clock selector codes
  // ****************************************************************
  localparam logic [3:0] MODE_PFC_ICR  = 4'h8;
  localparam logic [3:0] MODE_PFC_OCR  = 4'h9;
  localparam logic [3:0] MODE_PC_ICR   = 4'hA;
  localparam logic [3:0] MODE_PC_OCR   = 4'hB;
  localparam logic [3:0] MODE_CTC_ICR  = 4'hC;
  localparam logic [3:0] MODE_FAST_ICR = 4'hE;
  localparam logic [3:0] MODE_FAST_OCR = 4'hF;
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_FALL = 3'h6;
  localparam logic [2:0] CS_RISE = 3'h7;
  localparam logic [1:0] SEL_OFF    = 2'h0;
  localparam logic [1:0] SEL_TOGGLE = 2'h1;
  localparam logic [1:0] SEL_CLEAR  = 2'h2;

  typedef enum logic [1:0] {WAVE_NONPWM, WAVE_FAST, WAVE_DUAL} tcr_wave_t;

  // Classify a waveform mode into its output behaviour family
  function automatic tcr_wave_t wave_kind(input logic [3:0] m);
    unique case (m)
      4'h5, 4'h6, 4'h7, MODE_FAST_ICR, MODE_FAST_OCR: wave_kind = WAVE_FAST;
      4'h1, 4'h2, 4'h3, MODE_PFC_ICR, MODE_PFC_OCR,
      MODE_PC_ICR, MODE_PC_OCR: wave_kind = WAVE_DUAL;
      default: wave_kind = WAVE_NONPWM;
    endcase
  endfunction

  // Low-bit mask of the prescaler for each divider code
  function automatic logic [9:0] div_mask(input logic [2:0] cs);
    unique case (cs)
      3'h1:    div_mask = 10'h000;
      3'h2:    div_mask = 10'h007;
      3'h3:    div_mask = 10'h03F;
      3'h4:    div_mask = 10'h0FF;
      3'h5:    div_mask = 10'h3FF;
      default: div_mask = 10'h000;
    endcase
  endfunction
endpackage
`default_nettype wire

/* File: tcr_ctrl.sv */
// Timer control registers, compare output stage, clock select, capture
//
// The Wishbone interface to the registers and the register offsets were decided locally.
`default_nettype none
module tcr_ctrl
  import tcr_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Wishbone classic slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Counter core, same clock
  input  wire logic [15:0] counter_value_i,
  input  wire logic [2:0]  match_i,
  input  wire logic [2:0]  match_at_top_i,
  input  wire logic        at_bottom_i,
  input  wire logic        count_up_i,
  output logic             count_tick_o,
  output logic [3:0]       waveform_mode_sel_o,
  output logic             capture_event_flag_o,
  // Port pins
  input  wire logic [2:0]  port_dir_i,
  input  wire logic [2:0]  port_data_i,
  output logic [2:0]       pin_out_o,
  output logic [2:0]       pin_oe_o,
  input  wire logic        external_count_pin_i,
  input  wire logic        capture_input_pin_i
);

  // ****************************************************************
  // Registers and state
  // ****************************************************************
  logic [7:0]  ctrl_first;
  logic [7:0]  ctrl_second;
  logic [15:0] capture_value_reg;
  logic        capture_event_flag;
  logic [2:0]  compare_out;
  logic [9:0]  prescale;
  logic [1:0]  ext_sync;
  logic        ext_prev;
  logic [1:0]  cap_sync;
  logic [FILTER_LEN-1:0] cap_hist;
  logic        cap_filtered;
  logic        cap_prev;

  // ****************************************************************
  // Field decode
  // ****************************************************************
  wire [1:0] chan_a_output_select = ctrl_first[SEL_A_HI -: 2];
  wire [1:0] chan_b_output_select = ctrl_first[SEL_B_HI -: 2];
  wire [1:0] chan_c_output_select = ctrl_first[SEL_C_HI -: 2];
  wire [1:0] waveform_mode_low    = ctrl_first[1:0];
  wire [1:0] waveform_mode_high   = ctrl_second[4:3];
  wire [3:0] waveform_mode_sel    = {waveform_mode_high,
                                     waveform_mode_low};
  wire       capture_filter_enable = ctrl_second[FILTER_BIT];
  wire       capture_edge_select   = ctrl_second[EDGE_BIT];
  wire [2:0] count_clock_select    = ctrl_second[2:0];
  wire [5:0] sel_all = {chan_c_output_select, chan_b_output_select,
                        chan_a_output_select};
  tcr_wave_t wave;
  assign wave = wave_kind(waveform_mode_sel);

  // ****************************************************************
  // Wishbone decode
  // ****************************************************************
  wire bus_req   = cyc_i && stb_i && !ack_o;
  wire bus_wr    = bus_req && we_i && sel_i[0];
  wire wr_first  = bus_wr && (adr_i == ADDR_CTRL_FIRST);
  wire wr_second = bus_wr && (adr_i == ADDR_CTRL_SECOND);
  wire clr_flag  = bus_wr && (adr_i == ADDR_STATUS) && dat_i[FLAG_BIT];
  logic [31:0] next_dat;
  always_comb begin
    unique case (adr_i)
      ADDR_CTRL_FIRST:  next_dat = {24'h000000, ctrl_first};
      ADDR_CTRL_SECOND: next_dat = {24'h000000, ctrl_second};
      ADDR_STATUS:      next_dat = {31'h00000000, capture_event_flag};
      ADDR_CAPTURE:     next_dat = {16'h0000, capture_value_reg};
      default:          next_dat = 32'h00000000;
    endcase
  end

  // Bus answer one cycle after the request; unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else if (ce_i) begin
      ack_o <= bus_req;
      if (bus_req) dat_o <= next_dat;
    end
  end

  // Control registers; reserved bit 5 of the second register is never stored, reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_first  <= CTRL_RESET;
      ctrl_second <= CTRL_RESET;
    end else if (ce_i) begin
      if (wr_first) ctrl_first <= dat_i[7:0];
      if (wr_second) ctrl_second <= dat_i[7:0] & SECOND_WR_MASK;
    end
  end

  // ****************************************************************
  // Count clock select
  // ****************************************************************
  wire [9:0] pmask    = div_mask(count_clock_select);
  wire       pre_tick = (prescale & pmask) == pmask;
  // Pin is read regardless of its direction, so software can drive it
  wire ext_rise = ext_sync[1] && !ext_prev;
  wire ext_fall = !ext_sync[1] && ext_prev;
  logic next_tick;
  always_comb begin
    unique case (count_clock_select)
      CS_STOP: next_tick = 1'b0;
      CS_FALL: next_tick = ext_fall;
      CS_RISE: next_tick = ext_rise;
      default: next_tick = pre_tick;
    endcase
  end

  // Prescaler runs free; sharing it costs phase control on restart
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prescale     <= 10'h000;
      ext_sync     <= 2'b00;
      ext_prev     <= 1'b0;
      count_tick_o <= 1'b0;
    end else if (ce_i) begin
      prescale     <= prescale + 10'h001;
      ext_sync     <= {ext_sync[0], external_count_pin_i};
      ext_prev     <= ext_sync[1];
      count_tick_o <= next_tick;
    end
  end

  // ****************************************************************
  // Input capture
  // ****************************************************************
  wire icr_is_top = (waveform_mode_sel == MODE_PFC_ICR) ||
                    (waveform_mode_sel == MODE_PC_ICR)  ||
                    (waveform_mode_sel == MODE_CTC_ICR) ||
                    (waveform_mode_sel == MODE_FAST_ICR);
  wire hist_ones  = &cap_hist;
  wire hist_zeros = ~|cap_hist;
  // Filter output moves only after four equal samples
  wire next_filt  = hist_ones ? 1'b1 : (hist_zeros ? 1'b0 : cap_filtered);
  wire cap_level  = capture_filter_enable ? cap_filtered
                                          : cap_sync[1];
  wire cap_edge   = capture_edge_select ? (cap_level && !cap_prev)
                                        : (!cap_level && cap_prev);
  wire cap_take   = cap_edge && !icr_is_top;

  // Synchroniser, filter history and edge memory
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cap_sync     <= 2'b00;
      cap_hist     <= '0;
      cap_filtered <= 1'b0;
      cap_prev     <= 1'b0;
    end else if (ce_i) begin
      cap_sync     <= {cap_sync[0], capture_input_pin_i};
      cap_hist     <= {cap_hist[FILTER_LEN-2:0], cap_sync[1]};
      cap_filtered <= next_filt;
      cap_prev     <= cap_level;
    end
  end

  // Capture value and flag; a new capture wins over a clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      capture_value_reg  <= 16'h0000;
      capture_event_flag <= 1'b0;
    end else if (ce_i) begin
      if (cap_take) capture_value_reg <= counter_value_i;
      if (cap_take) capture_event_flag <= 1'b1;
      else if (clr_flag) capture_event_flag <= 1'b0;
    end
  end

  // ****************************************************************
  // Compare output stage
  // ****************************************************************
  logic [2:0] next_oc;
  always_comb begin
    for (int c = 0; c < NCHAN; c++) begin
      logic [1:0] s;
      logic       inv;
      s       = sel_all[2*c +: 2];
      inv     = s[0];
      next_oc[c] = compare_out[c];
      unique case (wave)
        WAVE_NONPWM: begin
          if (match_i[c] && s != SEL_OFF) begin
            next_oc[c] = (s == SEL_TOGGLE) ? !compare_out[c] : s[0];
          end
        end
        WAVE_FAST: begin
          if (s == SEL_TOGGLE) begin
            if (c == 0 && match_i[c] &&
                (waveform_mode_sel == MODE_FAST_ICR ||
                 waveform_mode_sel == MODE_FAST_OCR)) begin
              next_oc[c] = !compare_out[c];
            end
          end else if (s[1]) begin
            if (at_bottom_i) next_oc[c] = !inv;
            if (match_i[c] && !match_at_top_i[c]) begin
              next_oc[c] = inv;
            end
          end
        end
        WAVE_DUAL: begin
          if (s == SEL_TOGGLE) begin
            if (c == 0 && match_i[c] &&
                (waveform_mode_sel == MODE_PFC_OCR ||
                 waveform_mode_sel == MODE_PC_OCR)) begin
              next_oc[c] = !compare_out[c];
            end
          end else if (s[1] && match_i[c]) begin
            // Code 10 is the non-inverted sense, 11 inverted
            next_oc[c] = count_up_i ? inv : !inv;
          end
        end
        default: next_oc[c] = compare_out[c];
      endcase
    end
  end

  // Selector 01 hands over all channels in non-PWM, in PWM only channel A in four modes
  wire in_nonpwm     = (wave == WAVE_NONPWM);
  wire fast_a_toggle = (waveform_mode_sel == MODE_FAST_ICR) ||
                       (waveform_mode_sel == MODE_FAST_OCR);
  wire dual_a_toggle = (waveform_mode_sel == MODE_PFC_OCR) ||
                       (waveform_mode_sel == MODE_PC_OCR);
  wire a_toggle_ok   = in_nonpwm || fast_a_toggle || dual_a_toggle;
  // Any other nonzero selector gives the pin to the timer
  wire [2:0] chan_connected = {
    chan_c_output_select[1] | (chan_c_output_select[0] & in_nonpwm),
    chan_b_output_select[1] | (chan_b_output_select[0] & in_nonpwm),
    chan_a_output_select[1] | (chan_a_output_select[0] & a_toggle_ok)
  };
  wire [2:0] next_pin = (chan_connected & next_oc) |
                        (~chan_connected & port_data_i);

  // Output levels and pin drive, registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      compare_out <= 3'b000;
      pin_out_o   <= 3'b000;
      pin_oe_o    <= 3'b000;
    end else if (ce_i) begin
      compare_out <= next_oc;
      pin_out_o   <= next_pin;
      pin_oe_o    <= port_dir_i;
    end
  end

  assign waveform_mode_sel_o  = waveform_mode_sel;
  assign capture_event_flag_o = capture_event_flag;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i iff ce_i); endclocking
  default disable iff (rst_i);

  reset_first_zero_a: assert property (
    $fell(rst_i) |-> ctrl_first == CTRL_RESET && ctrl_second[5] == 1'b0)
    else $error("control registers not zero after reset");
  pin_handover_a: assert property (
    chan_connected[0] |=> pin_out_o[0] == compare_out[0] &&
                          pin_oe_o == $past(port_dir_i))
    else $error("pin not handed to compare output");
  clock_stop_a: assert property (
    (count_clock_select == CS_STOP)[*2] |-> !count_tick_o)
    else $error("tick while clock stopped");
  ext_rise_a: assert property (
    count_clock_select == CS_RISE && ext_rise |=> count_tick_o)
    else $error("rising pin edge not counted");
  capture_copy_a: assert property (
    cap_take |=> capture_value_reg == $past(counter_value_i) &&
                 capture_event_flag)
    else $error("capture did not copy counter");
  capture_block_a: assert property (
    icr_is_top && !capture_event_flag |=> !capture_event_flag)
    else $error("capture while capture register is top");
  nonpwm_toggle_a: assert property (
    wave == WAVE_NONPWM && chan_a_output_select == SEL_TOGGLE &&
    match_i[0] |=> compare_out[0] != $past(compare_out[0]))
    else $error("no toggle on match");
  fast_bottom_a: assert property (
    wave == WAVE_FAST && chan_a_output_select == SEL_CLEAR &&
    at_bottom_i && !match_i[0] |=> compare_out[0])
    else $error("fast mode not set at bottom");
  fast_top_a: assert property (
    wave == WAVE_FAST && chan_a_output_select[1] && match_i[0] &&
    match_at_top_i[0] && !at_bottom_i |=> $stable(compare_out[0]))
    else $error("match at top not ignored");
  dual_up_a: assert property (
    wave == WAVE_DUAL && chan_a_output_select == SEL_CLEAR &&
    match_i[0] && count_up_i |=> !compare_out[0])
    else $error("dual slope up match did not clear");
  filter_hold_a: assert property (
    $changed(cap_filtered) |-> $past(hist_ones) || $past(hist_zeros))
    else $error("filter moved without four equal samples");
  ack_pulse_a: assert property (
    ack_o |=> !ack_o)
    else $error("bus ack longer than one cycle");
  first_write_a: assert property (
    wr_first |=> ctrl_first == $past(dat_i[7:0]))
    else $error("first control write lost");
  second_write_a: assert property (
    wr_second |=> ctrl_second[4:0] == $past(dat_i[4:0]) &&
                  !ctrl_second[5])
    else $error("second control write wrong");
  ext_fall_a: assert property (
    count_clock_select == CS_FALL && ext_fall |=> count_tick_o)
    else $error("falling pin edge not counted");
  ext_quiet_a: assert property (
    count_clock_select == CS_RISE && !ext_rise |=> !count_tick_o)
    else $error("tick without rising pin edge");
  nonpwm_set_a: assert property (
    wave == WAVE_NONPWM && &chan_a_output_select &&
    match_i[0] |=> compare_out[0])
    else $error("no set on match");
  fast_clear_a: assert property (
    wave == WAVE_FAST && chan_a_output_select == SEL_CLEAR &&
    match_i[0] && !match_at_top_i[0] |=> !compare_out[0])
    else $error("fast mode not cleared on match");
  fast_toggle_a: assert property (
    fast_a_toggle && chan_a_output_select == SEL_TOGGLE &&
    match_i[0] |=> compare_out[0] != $past(compare_out[0]))
    else $error("fast mode channel A did not toggle");
  fast_port_b_a: assert property (
    wave == WAVE_FAST && chan_b_output_select == SEL_TOGGLE |=>
    pin_out_o[1] == $past(port_data_i[1]))
    else $error("fast mode channel B not left to port");
  dual_toggle_a: assert property (
    dual_a_toggle && chan_a_output_select == SEL_TOGGLE &&
    match_i[0] |=> compare_out[0] != $past(compare_out[0]))
    else $error("dual slope channel A did not toggle");
  dual_port_c_a: assert property (
    wave == WAVE_DUAL && chan_c_output_select == SEL_TOGGLE |=>
    pin_out_o[2] == $past(port_data_i[2]))
    else $error("dual slope channel C not left to port");
  dual_down_a: assert property (
    wave == WAVE_DUAL && chan_a_output_select == SEL_CLEAR &&
    match_i[0] && !count_up_i |=> compare_out[0])
    else $error("dual slope down match did not set");
  dual_inverted_a: assert property (
    wave == WAVE_DUAL && &chan_a_output_select &&
    match_i[0] && count_up_i |=> compare_out[0])
    else $error("inverted dual slope up match did not set");
  chan_off_a: assert property (
    chan_a_output_select == SEL_OFF |=>
    pin_out_o[0] == $past(port_data_i[0]))
    else $error("disconnected pin not driven by port");
  edge_fall_a: assert property (
    !capture_edge_select && !icr_is_top && !cap_level && cap_prev |=>
    capture_event_flag)
    else $error("falling capture edge missed");

  cap_seen_c:  cover property (cap_take);
  ext_fall_c:  cover property (count_clock_select == CS_FALL && next_tick);
  fast_pwm_c:  cover property (wave == WAVE_FAST && at_bottom_i);
  flag_race_c: cover property (cap_take && clr_flag);
  dual_toggle_c: cover property (dual_a_toggle && match_i[0]);

endmodule // tcr_ctrl
`default_nettype wire

/* File: tcr_core_model.sv */
// Stand-in for the counter core that sits beside the control block
`default_nettype none
module tcr_core_model
  import tcr_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        tick_i,
  output logic      [15:0] counter_value_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************************************
  // Count register
  // ****************************************************************
  // One step per tick; a tick wider than a cycle would show as extra
  // counts, so the capture value would then disagree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      counter_value_o <= 16'h0000;
    end else if (tick_i) begin
      counter_value_o <= counter_value_o + 16'h0001;
    end
  end
endmodule // tcr_core_model
`default_nettype wire

/* File: test_timer16_control_regs.sv */
// Self-checking bench for the timer control register block
`default_nettype none
module test_timer16_control_regs
  import tcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        ce = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [3:0]  sel = 4'hF;
  logic [31:0] dat = 32'h0;
  logic [2:0]  match = 3'h0;
  logic [2:0]  mtop = 3'h0;
  logic        bot = 1'b0;
  logic        up = 1'b1;
  logic [2:0]  pdir = 3'h0;
  logic [2:0]  pd = 3'h0;
  logic        ext = 1'b0;
  logic        cap = 1'b0;
  wire  [31:0] dat_o;
  wire         ack;
  wire         tick;
  wire         flag;
  wire  [3:0]  wave;
  wire  [2:0]  pout;
  wire  [2:0]  poe;
  wire  [15:0] cnt;
  int          num_errors = 0;
  int          n_tests = 0;
  int          ticks = 0;
  int          cycles = 0;
  int          t0;
  logic [7:0]  r1;
  logic [7:0]  r2;
  logic        st;
  logic [1:0]  sels [4] = '{2'h3, 2'h2, 2'h1, 2'h1};

  tcr_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat),
    .dat_o(dat_o), .ack_o(ack), .counter_value_i(cnt), .match_i(match),
    .match_at_top_i(mtop), .at_bottom_i(bot), .count_up_i(up),
    .count_tick_o(tick), .waveform_mode_sel_o(wave),
    .capture_event_flag_o(flag), .port_dir_i(pdir), .port_data_i(pd),
    .pin_out_o(pout), .pin_oe_o(poe), .external_count_pin_i(ext),
    .capture_input_pin_i(cap));
  tcr_core_model i_core (.clk_i(clk_i), .rst_i(rst_i), .tick_i(tick),
    .counter_value_o(cnt));

  // ****************************************************************
  // Clock, tick counter, timeout
  // ****************************************************************
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  // Ticks sampled mid-cycle so the main thread never races them
  always @(negedge clk_i) begin
    if (tick === 1'b1) ticks++;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic tally_and_finish();
    $display("errors %0d compares %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cyc_n(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Classic cycle: hold everything until ack is seen at an edge
  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 20);
    q = dat_o;
    if (k == 20) begin
      num_errors++;
      $display("ERROR t=%0t no ack got=%h exp=%h", $time, ack, 1'b1);
    end
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  // One-cycle event pulse from the counter side, then settle
  task automatic ev(input logic [2:0] m, input logic [2:0] t,
                    input logic b, input logic u);
    match <= m;
    mtop  <= t;
    bot   <= b;
    up    <= u;
    @(posedge clk_i);
    match <= 3'h0;
    bot   <= 1'b0;
    cyc_n(3);
  endtask
  task automatic cmp(input logic [7:0] f, input logic [7:0] s,
                     input logic [2:0] m, input logic [2:0] t,
                     input logic b, input logic u, input logic [2:0] e);
    wr(ADDR_CTRL_FIRST, 32'(f));
    wr(ADDR_CTRL_SECOND, 32'(s));
    ev(m, t, b, u);
    chk(32'(pout), 32'(e));
    mtop <= 3'h0;
  endtask
  // Next compare output level in the non-PWM modes
  function automatic logic nonpwm(input logic [1:0] s, input logic c);
    case (s)
      2'h1: return ~c;
      2'h2: return 1'b0;
      2'h3: return 1'b1;
      default: return c;
    endcase
  endfunction
  function automatic int divisor(input int c);
    case (c)
      1: return 1;
      2: return 8;
      3: return 64;
      4: return 256;
      default: return 1024;
    endcase
  endfunction

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    void'($urandom(48330));
    cyc_n(16);
    rst_i <= 1'b0;
    for (int a = 0; a < 4; a++) begin
      rd(4'(a * 4), 32'h0);
    end
    rd(4'h2, 32'h0);
    // Random settings, bit 5 kept clear as software must
    repeat (8) begin
      r1 = 8'($urandom);
      r2 = 8'($urandom) & SECOND_WR_MASK;
      wr(ADDR_CTRL_FIRST, 32'(r1));
      wr(ADDR_CTRL_SECOND, 32'(r2));
      rd(ADDR_CTRL_FIRST, 32'(r1));
      rd(ADDR_CTRL_SECOND, 32'(r2));
      chk(32'(wave), 32'({r2[4:3], r1[1:0]}));
    end
    for (int c = 0; c < 6; c++) begin
      wr(ADDR_CTRL_SECOND, 32'(c));
      cyc_n(4);
      t0 = ticks;
      cyc_n(c == 0 ? 40 : 10 * divisor(c));
      chk(32'(ticks - t0), c == 0 ? 32'h0 : 32'hA);
    end
    // Pin driven as output still counts; four falls, five rises
    pdir <= 3'h7;
    for (int c = 6; c < 8; c++) begin
      wr(ADDR_CTRL_SECOND, 32'(c));
      t0 = ticks;
      repeat (4) begin
        ext <= 1'b1;
        cyc_n(4);
        ext <= 1'b0;
        cyc_n(4);
      end
      ext <= 1'b1;
      cyc_n(8);
      chk(32'(ticks - t0), c == 7 ? 32'h5 : 32'h4);
      ext <= 1'b0;
      cyc_n(4);
    end
    pd <= 3'($urandom);
    wr(ADDR_CTRL_SECOND, 32'h0);
    st = 1'b0;
    foreach (sels[i]) begin
      wr(ADDR_CTRL_FIRST, 32'({sels[i], sels[i], sels[i], 2'h0}));
      ev(3'h7, 3'h0, 1'b0, 1'b1);
      st = nonpwm(sels[i], st);
      chk(32'(pout), 32'({3{st}}));
    end
    // Clock enable low must swallow a match
    ce <= 1'b0;
    ev(3'h7, 3'h0, 1'b0, 1'b1);
    ce <= 1'b1;
    chk(32'(pout), 32'({3{st}}));
    wr(ADDR_CTRL_FIRST, 32'h0);
    cyc_n(3);
    chk(32'(pout), 32'(pd));
    pdir <= 3'h2;
    cyc_n(3);
    chk(32'(poe), 32'h2);
    pdir <= 3'h7;
    cmp(8'hAA, 8'h18, 3'h0, 3'h0, 1'b1, 1'b1, 3'h7);
    cmp(8'hAA, 8'h18, 3'h7, 3'h7, 1'b0, 1'b1, 3'h7);
    cmp(8'hAA, 8'h18, 3'h7, 3'h0, 1'b0, 1'b1, 3'h0);
    cmp(8'hFE, 8'h18, 3'h0, 3'h0, 1'b1, 1'b1, 3'h0);
    cmp(8'hFE, 8'h18, 3'h7, 3'h0, 1'b0, 1'b1, 3'h7);
    cmp(8'h56, 8'h18, 3'h7, 3'h0, 1'b0, 1'b1, {pd[2:1], 1'b0});
    cmp(8'h55, 8'h08, 3'h7, 3'h0, 1'b0, 1'b1, pd);
    cmp(8'hA8, 8'h10, 3'h7, 3'h0, 1'b0, 1'b1, 3'h0);
    cmp(8'hA8, 8'h10, 3'h7, 3'h0, 1'b0, 1'b0, 3'h7);
    cmp(8'hFC, 8'h10, 3'h7, 3'h0, 1'b0, 1'b0, 3'h0);
    cmp(8'hFC, 8'h10, 3'h7, 3'h0, 1'b0, 1'b1, 3'h7);
    cmp(8'h55, 8'h10, 3'h7, 3'h0, 1'b0, 1'b1, {pd[2:1], 1'b0});
    cmp(8'h56, 8'h10, 3'h7, 3'h0, 1'b0, 1'b1, pd);
    // Capture with the counter stopped so its value is fixed
    wr(ADDR_CTRL_FIRST, 32'h0);
    wr(ADDR_CTRL_SECOND, 32'h40);
    cap <= 1'b1;
    cyc_n(8);
    chk(32'(flag), 32'h1);
    rd(ADDR_CAPTURE, 32'(cnt));
    rd(ADDR_STATUS, 32'h1);
    wr(ADDR_STATUS, 32'h1);
    cap <= 1'b0;
    cyc_n(8);
    chk(32'(flag), 32'h0);
    wr(ADDR_CTRL_SECOND, 32'h0);
    cap <= 1'b1;
    cyc_n(8);
    chk(32'(flag), 32'h0);
    cap <= 1'b0;
    cyc_n(8);
    chk(32'(flag), 32'h1);
    wr(ADDR_STATUS, 32'h1);
    wr(ADDR_CTRL_SECOND, 32'h58);
    cap <= 1'b1;
    cyc_n(8);
    chk(32'(flag), 32'h0);
    cap <= 1'b0;
    wr(ADDR_CTRL_SECOND, 32'hC0);
    cap <= 1'b1;
    cyc_n(2);
    cap <= 1'b0;
    cyc_n(10);
    chk(32'(flag), 32'h0);
    cap <= 1'b1;
    cyc_n(12);
    chk(32'(flag), 32'h1);
    tally_and_finish();
  end
endmodule // test_timer16_control_regs
`default_nettype wire
